// [rtl/orps_pkg.sv]
// Shared constants and types for the output ramp and protection supervisor.
// Assumes a 50 MHz ref_clk and a 500 kHz master clock seen as a synchronous input.
package orps_pkg;
   // Register addresses
   localparam logic [7:0] ADDR_PROT_CFG  = 8'h01;
   localparam logic [7:0] ADDR_RAMP_CFG  = 8'h03;
   localparam logic [7:0] ADDR_OFF_DELAY = 8'h06;
   localparam logic [7:0] ADDR_CUR_LIMIT = 8'h08;
   localparam logic [7:0] ADDR_RUN       = 8'h15;
   localparam logic [7:0] ADDR_STATUS    = 8'h16;
   localparam logic [7:0] ADDR_PG_DELAY  = 8'h1a;
   localparam logic [7:0] ADDR_PG_MODE   = 8'h1b;
   // Threshold configuration fields and reset
   localparam int         PC_PGH_BIT     = 5;
   localparam int         PC_PGL_BIT     = 4;
   localparam int         PC_OV_LSB      = 2;
   localparam int         PC_UV_LSB      = 0;
   localparam logic [5:0] PROT_CFG_RESET = 6'h08;
   // Ramp configuration fields: rising code low nibble, falling code high nibble
   localparam int         RC_RISE_LSB    = 0;
   localparam int         RC_FALL_LSB    = 4;
   localparam int         DWELL_UNIT     = 2;
   // Status register bits and reset
   localparam int         ST_OC_BIT      = 0;
   localparam int         ST_PG_BIT      = 1;
   localparam int         ST_TW_BIT      = 2;
   localparam logic [7:0] STATUS_RESET   = 8'h03;
   // Percentages of the active setpoint
   localparam logic [7:0] PCT_75  = 8'h4b;
   localparam logic [7:0] PCT_80  = 8'h50;
   localparam logic [7:0] PCT_85  = 8'h55;
   localparam logic [7:0] PCT_90  = 8'h5a;
   localparam logic [7:0] PCT_95  = 8'h5f;
   localparam logic [7:0] PCT_105 = 8'h69;
   localparam logic [7:0] PCT_110 = 8'h6e;
   localparam logic [7:0] PCT_120 = 8'h78;
   localparam logic [7:0] PCT_130 = 8'h82;
   localparam int         PCT_DIV = 100;
   // Voltage and timing figures
   localparam int         VW          = 12;
   localparam int         VSET_LSB_UV = 2500;
   localparam int         STEP_MV     = 10;
   localparam int         STEP_LSB    = STEP_MV * 1000 / VSET_LSB_UV;
   localparam int         MASTER_KHZ  = 500;
   localparam logic [7:0] PG_DELAY_MAX_MS = 8'h96;
   localparam logic [7:0] TW_SET_C    = 8'h78;
   localparam logic [7:0] TW_CLR_C    = 8'h75;

   typedef enum logic [2:0] {S_OFF, S_RAMP_UP, S_STEADY, S_OFF_WAIT, S_RAMP_DOWN, S_TRIPPED} orps_state_t;
endpackage : orps_pkg

// [rtl/orps_step_if.sv]
// Carrier between the supervisor and its ramp step pacer.
// Assumes both ends share ref_clk.
`timescale 1ns/100ps
interface orps_step_if;
   logic       master_tick;
   logic [4:0] dwell;
   logic       active;
   logic       step;
   modport ctl   (output master_tick, output dwell, output active, input step);
   modport pacer (input master_tick, input dwell, input active, output step);
endinterface : orps_step_if

// [rtl/orps_step_pacer.sv]
// Ramp step pacer: one step pulse per dwell count of master clock ticks.
// Assumes master_tick is a one-cycle pulse per master clock rising edge.
`timescale 1ns/100ps
module orps_step_pacer
   import orps_pkg::*;
(
   input wire logic   ref_clk,
   input wire logic   reset,
   orps_step_if.pacer sif
);
   logic [4:0] cnt;

   // Dwell counter; only master ticks advance it so all converters match
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         cnt      <= 5'h00;
         sif.step <= 1'b0;
      end else begin
         sif.step <= 1'b0;
         if (!sif.active) begin
            cnt <= 5'h00;
         end else if (sif.master_tick) begin
            if (cnt + 5'h01 >= sif.dwell) begin
               cnt      <= 5'h00;
               sif.step <= 1'b1;
            end else begin
               cnt <= cnt + 5'h01;
            end
         end
      end
   end

   // A step only follows a master tick
   a_step_from_tick: assert property (@(posedge ref_clk) disable iff (reset)
      sif.step |-> $past(sif.master_tick) && $past(sif.active))
      else $error("ramp step without master tick");
endmodule : orps_step_pacer

// [rtl/orps_pct_scale.sv]
// Scales the active setpoint by a percentage into an absolute level.
// Assumes vset may change at any time; level follows one cycle later.
`timescale 1ns/100ps
module orps_pct_scale
   import orps_pkg::*;
(
   input  wire logic          ref_clk,
   input  wire logic          reset,
   input  wire logic [VW-1:0] vset,
   input  wire logic [7:0]    pct,
   output logic      [VW:0]   level
);
   logic [VW+7:0] prod;

   // Divide by a constant keeps the level exact to the setpoint LSB
   assign prod = (VW+8)'(vset) * (VW+8)'(pct);

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         level <= '0;
      end else begin
         level <= (VW+1)'(prod / (VW+8)'(PCT_DIV));
      end
   end
endmodule : orps_pct_scale

// [rtl/orps_supervisor.sv]
// Ramp, turn-off delay, power-good and protection supervisor of a load converter.
// Assumes register port and all measurements are synchronous to ref_clk.
`timescale 1ns/100ps
module orps_supervisor
   import orps_pkg::*;
#(
   parameter int TICKS_PER_MS = MASTER_KHZ
)
(
   input  wire logic          ref_clk,
   input  wire logic          reset,
   input  wire logic          master_clk,
   input  wire logic [7:0]    reg_addr,
   input  wire logic [7:0]    reg_wdata,
   input  wire logic          reg_wr,
   input  wire logic          reg_rd,
   output logic      [7:0]    reg_rdata,
   input  wire logic [VW-1:0] vset,
   input  wire logic [VW-1:0] vout_meas,
   input  wire logic [7:0]    iout_meas,
   input  wire logic [7:0]    temp_meas,
   input  wire logic          pg_in,
   output logic               pg_out,
   output logic               pg_oe_n,
   output logic      [VW-1:0] vref,
   output logic               switch_en,
   output logic      [VW:0]   ov_level,
   output logic      [VW:0]   uv_level
);
   orps_state_t  state;
   logic [5:0]   prot_cfg;
   logic [7:0]   ramp_cfg;
   logic [7:0]   off_delay;
   logic [7:0]   cur_limit;
   logic         run;
   logic [7:0]   pg_delay;
   logic         pg_at_command;
   logic         oc_ok;
   logic         pg_status;
   logic         tw;
   logic         master_q;
   logic [VW-1:0] prebias_level;
   logic [17:0]  wait_cnt;
   logic [17:0]  pg_cnt;
   logic         pg_released;
   logic [VW:0]  pg_upper;
   logic [VW:0]  pg_lower;
   logic [7:0]   pct_hi;
   logic [7:0]   pct_lo;
   logic [7:0]   pct_ov;
   logic [7:0]   pct_uv;
   logic [3:0]   rise_code;
   logic [3:0]   fall_code;
   logic [4:0]   rise_dwell;
   logic [4:0]   fall_dwell;
   logic [17:0]  off_ticks;
   logic [17:0]  ramp_ticks;
   logic [17:0]  pg_ticks;
   logic [VW-1:0] next_vref;
   logic         oc_hit;
   logic         pg_hold;
   logic         outside;
   logic         ext_pull;
   logic         pg_warn;
   logic [7:0]   rd_mux;

   orps_step_if sif ();

   orps_step_pacer u_pacer (
      .ref_clk (ref_clk),
      .reset   (reset),
      .sif     (sif)
   );

   // Master clock edge detect; input is already synchronous
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         master_q <= 1'b0;
      end else begin
         master_q <= master_clk;
      end
   end

   // Pacing: rate code sets dwell only, a zero rising code runs fastest
   assign rise_code       = ramp_cfg[RC_RISE_LSB +: 4];
   assign fall_code       = ramp_cfg[RC_FALL_LSB +: 4];
   assign rise_dwell      = 5'((rise_code == 4'h0 ? 4'h1 : rise_code) * DWELL_UNIT);
   assign fall_dwell      = 5'(fall_code * DWELL_UNIT);
   assign sif.master_tick = master_clk & ~master_q;
   assign sif.active      = (state == S_RAMP_UP) || (state == S_STEADY) || (state == S_RAMP_DOWN);
   assign sif.dwell       = (state == S_RAMP_DOWN) ? fall_dwell : rise_dwell;

   // Turn-off timing in master ticks; a partial last step still costs a whole dwell
   assign off_ticks  = 18'(18'(off_delay) * 18'(TICKS_PER_MS));
   assign ramp_ticks = 18'(((18'(vref) + 18'(STEP_LSB - 1)) / 18'(STEP_LSB)) * 18'(fall_dwell));
   assign pg_ticks   = 18'(18'(pg_delay) * 18'(TICKS_PER_MS));

   // One step toward the active setpoint, never overshooting it
   always_comb begin
      if (vref < vset) begin
         next_vref = ((vset - vref) > VW'(STEP_LSB)) ? vref + VW'(STEP_LSB) : vset;
      end else begin
         next_vref = ((vref - vset) > VW'(STEP_LSB)) ? vref - VW'(STEP_LSB) : vset;
      end
   end

   // Trip only counts once the output is above any pre-bias
   assign oc_hit = switch_en && (vout_meas > prebias_level) && (iout_meas >= cur_limit);

   // Sequencing: ramp up, track, delayed off, ramp down, trip
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         state         <= S_OFF;
         vref          <= '0;
         switch_en     <= 1'b0;
         prebias_level <= '0;
         wait_cnt      <= 18'h00000;
      end else begin
         case (state)
            S_OFF: begin
               vref      <= '0;
               switch_en <= 1'b0;
               if (run) begin
                  prebias_level <= vout_meas;
                  state         <= S_RAMP_UP;
               end
            end
            S_RAMP_UP, S_STEADY: begin
               if (oc_hit) begin
                  switch_en <= 1'b0;
                  vref      <= '0;
                  state     <= S_TRIPPED;
               end else if (!run) begin
                  // Without falling ramp the whole delay ends in opening the switches
                  if (fall_code == 4'h0) begin
                     wait_cnt <= off_ticks;
                  end else begin
                     wait_cnt <= (off_ticks > ramp_ticks) ? off_ticks - ramp_ticks : 18'h00000;
                  end
                  state <= S_OFF_WAIT;
               end else begin
                  if (vref >= prebias_level) begin
                     switch_en <= 1'b1;
                  end
                  if (sif.step) begin
                     vref <= next_vref;
                  end
                  if (state == S_RAMP_UP && vref == vset) begin
                     state <= S_STEADY;
                  end
               end
            end
            S_OFF_WAIT: begin
               if (oc_hit) begin
                  switch_en <= 1'b0;
                  vref      <= '0;
                  state     <= S_TRIPPED;
               end else if (wait_cnt == 18'h00000) begin
                  if (fall_code == 4'h0) begin
                     switch_en <= 1'b0;
                     vref      <= '0;
                     state     <= S_OFF;
                  end else begin
                     state <= S_RAMP_DOWN;
                  end
               end else if (sif.master_tick) begin
                  wait_cnt <= wait_cnt - 18'h00001;
               end
            end
            S_RAMP_DOWN: begin
               if (oc_hit) begin
                  switch_en <= 1'b0;
                  vref      <= '0;
                  state     <= S_TRIPPED;
               end else if (vref == '0) begin
                  switch_en <= 1'b0;
                  state     <= S_OFF;
               end else if (sif.step) begin
                  vref <= (vref > VW'(STEP_LSB)) ? vref - VW'(STEP_LSB) : '0;
               end
            end
            S_TRIPPED: begin
               switch_en <= 1'b0;
               vref      <= '0;
               if (!run) begin
                  state <= S_OFF;
               end
            end
            default: begin
               state <= S_OFF;
            end
         endcase
      end
   end

   // Overcurrent status: trip clears it, next turn-on restores it
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         oc_ok <= STATUS_RESET[ST_OC_BIT];
      end else if (oc_hit) begin
         oc_ok <= 1'b0;
      end else if (state == S_OFF && run) begin
         oc_ok <= 1'b1;
      end
   end

   // Register writes; threshold config locked while running
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         prot_cfg      <= PROT_CFG_RESET;
         ramp_cfg      <= 8'h00;
         off_delay     <= 8'h00;
         cur_limit     <= 8'hff;
         run           <= 1'b0;
         pg_delay      <= 8'h00;
         pg_at_command <= 1'b0;
      end else if (reg_wr) begin
         case (reg_addr)
            ADDR_PROT_CFG:  if (!run) prot_cfg <= reg_wdata[5:0];
            ADDR_RAMP_CFG:  ramp_cfg <= reg_wdata;
            ADDR_OFF_DELAY: off_delay <= reg_wdata;
            ADDR_CUR_LIMIT: cur_limit <= reg_wdata;
            ADDR_RUN:       run <= reg_wdata[0];
            ADDR_PG_DELAY:  pg_delay <= (reg_wdata > PG_DELAY_MAX_MS) ? PG_DELAY_MAX_MS : reg_wdata;
            ADDR_PG_MODE:   pg_at_command <= reg_wdata[0];
            default:        ;
         endcase
      end
   end

   // Read data registered; unmapped addresses read zero
   always_comb begin
      case (reg_addr)
         ADDR_PROT_CFG:  rd_mux = {2'b00, prot_cfg};
         ADDR_RAMP_CFG:  rd_mux = ramp_cfg;
         ADDR_OFF_DELAY: rd_mux = off_delay;
         ADDR_CUR_LIMIT: rd_mux = cur_limit;
         ADDR_RUN:       rd_mux = {7'h00, run};
         ADDR_STATUS:    rd_mux = {5'h00, tw, pg_status, oc_ok};
         ADDR_PG_DELAY:  rd_mux = pg_delay;
         ADDR_PG_MODE:   rd_mux = {7'h00, pg_at_command};
         default:        rd_mux = 8'h00;
      endcase
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         reg_rdata <= 8'h00;
      end else begin
         reg_rdata <= reg_rd ? rd_mux : 8'h00;
      end
   end

   // Percent selection for the four thresholds
   assign pct_hi = prot_cfg[PC_PGH_BIT] ? PCT_105 : PCT_110;
   assign pct_lo = prot_cfg[PC_PGL_BIT] ? PCT_95 : PCT_90;
   assign pct_ov = (prot_cfg[PC_OV_LSB +: 2] == 2'b00) ? PCT_110 :
                   (prot_cfg[PC_OV_LSB +: 2] == 2'b01) ? PCT_120 : PCT_130;
   assign pct_uv = (prot_cfg[PC_UV_LSB +: 2] == 2'b00) ? PCT_75 :
                   (prot_cfg[PC_UV_LSB +: 2] == 2'b01) ? PCT_80 :
                   (prot_cfg[PC_UV_LSB +: 2] == 2'b10) ? PCT_85 : PCT_90;

   // Levels follow vset, so margining moves them too
   orps_pct_scale u_pg_hi (.ref_clk(ref_clk), .reset(reset), .vset(vset), .pct(pct_hi), .level(pg_upper));
   orps_pct_scale u_pg_lo (.ref_clk(ref_clk), .reset(reset), .vset(vset), .pct(pct_lo), .level(pg_lower));
   orps_pct_scale u_ov    (.ref_clk(ref_clk), .reset(reset), .vset(vset), .pct(pct_ov), .level(ov_level));
   orps_pct_scale u_uv    (.ref_clk(ref_clk), .reset(reset), .vset(vset), .pct(pct_uv), .level(uv_level));

   // Good window held in steady state, and during the wait if pin falls at ramp-down
   assign pg_hold  = (state == S_STEADY) || (state == S_OFF_WAIT && !pg_at_command);
   assign outside  = ({1'b0, vout_meas} > pg_upper) || ({1'b0, vout_meas} < pg_lower);
   assign ext_pull = pg_oe_n && !pg_in;
   assign pg_warn  = pg_released && (outside || ext_pull);

   // Release delay counted in master ticks once steady state is seen
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         pg_cnt      <= 18'h00000;
         pg_released <= 1'b0;
      end else if (!pg_hold) begin
         pg_cnt      <= 18'h00000;
         pg_released <= 1'b0;
      end else if (!pg_released) begin
         if (pg_cnt >= pg_ticks) begin
            pg_released <= 1'b1;
         end else if (sif.master_tick) begin
            pg_cnt <= pg_cnt + 18'h00001;
         end
      end
   end

   // Open-drain good pin; only a status indication, never a shutdown
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         pg_out    <= 1'b0;
         pg_oe_n   <= 1'b0;
         pg_status <= STATUS_RESET[ST_PG_BIT];
      end else begin
         pg_out    <= 1'b0;
         pg_oe_n   <= pg_released && !outside;
         pg_status <= !pg_warn;
      end
   end

   // Thermal warning with hysteresis
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         tw <= STATUS_RESET[ST_TW_BIT];
      end else if (temp_meas > TW_SET_C) begin
         tw <= 1'b1;
      end else if (temp_meas < TW_CLR_C) begin
         tw <= 1'b0;
      end
   end

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (reset);

   sequence s_oc_event;
      oc_hit;
   endsequence

   sequence s_switch_open;
      !switch_en && !oc_ok && state == S_TRIPPED;
   endsequence

   a_cfg_locked: assert property ((reg_wr && reg_addr == ADDR_PROT_CFG && run) |=> $stable(prot_cfg))
      else $error("threshold config changed while running");
   a_cfg_upper_zero: assert property ((reg_rd && reg_addr == ADDR_PROT_CFG) |=> reg_rdata[7:6] == 2'b00)
      else $error("threshold config upper bits not zero");
   a_step_size: assert property ((state == S_RAMP_UP && $past(state) == S_RAMP_UP && vref != $past(vref))
      |-> (vref > $past(vref)) && (vref - $past(vref) <= VW'(STEP_LSB)))
      else $error("rising step not one fixed increment");
   a_down_step: assert property ((state == S_RAMP_DOWN && sif.step && !oc_hit && vref > VW'(STEP_LSB))
      |=> vref == $past(vref) - VW'(STEP_LSB))
      else $error("falling step wrong size");
   a_oc_trip: assert property (s_oc_event |=> s_switch_open ##1 !switch_en)
      else $error("overcurrent did not open switches");
   a_prebias_hold: assert property ((state == S_RAMP_UP && run && !switch_en && vref < prebias_level)
      |=> !switch_en)
      else $error("switching began below pre-bias");
   a_warn_no_stop: assert property ((state == S_STEADY && run && !oc_hit && (tw || pg_warn))
      |=> state == S_STEADY)
      else $error("warning shut converter down");
   a_tw_hyst: assert property ((temp_meas > TW_SET_C) |=> tw ##1 (tw || $past(temp_meas) < TW_CLR_C))
      else $error("thermal warning hysteresis broken");
   a_pg_outside: assert property ((pg_hold && outside) |=> !pg_oe_n)
      else $error("good pin not low outside window");
   a_pg_status: assert property ((pg_released && ext_pull) |=> !pg_status)
      else $error("external good pull not reported");
   a_off_nonslew: assert property ((state == S_OFF_WAIT && wait_cnt == 18'h00000 && fall_code == 4'h0 && !oc_hit)
      |=> !switch_en && state == S_OFF)
      else $error("switches not opened at delay end");
endmodule : orps_supervisor

// [testbench/orps_mgr_model.sv]
// Power manager model: supplies the 500 kHz master clock.
// Assumes a 50 MHz ref_clk; the clock edges follow ref_clk edges.
`timescale 1ns/100ps
module orps_mgr_model (
   input wire logic ref_clk,
   input wire logic reset,
   output logic     master_clk
);
   logic [5:0] half_cnt;
   // Toggle every 50 ref cycles, giving 500 kHz
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         half_cnt   <= 6'h00;
         master_clk <= 1'b0;
      end else if (half_cnt == 6'h31) begin
         half_cnt   <= 6'h00;
         master_clk <= ~master_clk;
      end else begin
         half_cnt <= half_cnt + 6'h01;
      end
   end
endmodule : orps_mgr_model

// [testbench/orps_supervisor_tb_top.sv]
// Self-checking bench of the output ramp and protection supervisor.
// Assumes the design's package and the manager model are compiled first.
`timescale 1ns/100ps
module orps_supervisor_tb_top;
   import orps_pkg::*;
   logic ref_clk, reset, master_clk, reg_wr, reg_rd, pg_out, pg_oe_n, switch_en, ext_low;
   logic [7:0]    reg_addr, reg_wdata, reg_rdata, iout_meas, temp_meas, rd_val;
   logic [VW-1:0] vset, vout_meas, vref;
   logic [VW:0]   ov_level, uv_level;
   int            err_total, tests_run;
   // Pulled-up good wire; the device or an outside party may pull it low
   wire           pg_in = pg_oe_n & ~ext_low;
   orps_mgr_model mgr_u (.ref_clk(ref_clk), .reset(reset), .master_clk(master_clk));
   orps_supervisor #(.TICKS_PER_MS(2)) dut_u (.ref_clk(ref_clk), .reset(reset), .master_clk(master_clk),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .vset(vset), .vout_meas(vout_meas), .iout_meas(iout_meas), .temp_meas(temp_meas), .pg_in(pg_in),
      .pg_out(pg_out), .pg_oe_n(pg_oe_n), .vref(vref), .switch_en(switch_en), .ov_level(ov_level),
      .uv_level(uv_level));
   // Clock at 20 ns period
   initial begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end
   task automatic chk(input logic [VW:0] got, input logic [VW:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      #1 reg_addr = a; reg_wdata = d; reg_wr = 1'b1;
      @(posedge ref_clk);
      #1 reg_wr = 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a);
      @(posedge ref_clk);
      #1 reg_addr = a; reg_rd = 1'b1;
      @(posedge ref_clk);
      #1 reg_rd = 1'b0;
      rd_val = reg_rdata;
   endtask : rd
   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask : cyc
   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : print_verdict
   // Reset values, config fields and scaling with the setpoint
   task automatic t_config;
      rd(ADDR_PROT_CFG); chk(rd_val, 8'h08);
      rd(ADDR_STATUS); chk(rd_val, 8'h03);
      chk(ov_level, 13'h208);
      wr(ADDR_PROT_CFG, 8'hff); rd(ADDR_PROT_CFG); chk(rd_val, 8'h3f);
      cyc(2); chk(ov_level, 13'h208); chk(uv_level, 13'h168);
      wr(ADDR_PROT_CFG, 8'h06); cyc(2); chk(ov_level, 13'h1e0); chk(uv_level, 13'h154);
      vset = 12'h0c8; cyc(2); chk(ov_level, 13'h0f0); chk(uv_level, 13'h0aa);
      vset = 12'h028; cyc(2);
   endtask : t_config
   // Turn on, ramp in 4-LSB steps, refuse config while running
   task automatic t_ramp;
      logic [VW-1:0] prev;
      int            n;
      wr(ADDR_CUR_LIMIT, 8'h40);
      wr(ADDR_RUN, 8'h01);
      wr(ADDR_PROT_CFG, 8'h00); rd(ADDR_PROT_CFG); chk(rd_val, 8'h06);
      prev = vref;
      for (n = 0; n < 8000 && vref !== vset; n++) begin
         cyc(1);
         if (vref !== prev) chk(vref - prev, 13'h004);
         prev = vref;
      end
      chk(vref, vset);
      cyc(2); chk(switch_en, 1'b1);
      vout_meas = vset;
   endtask : t_ramp
   // Thermal warning hysteresis without shutdown
   task automatic t_thermal;
      temp_meas = 8'h79; cyc(3); rd(ADDR_STATUS); chk(rd_val[ST_TW_BIT], 1'b1);
      temp_meas = 8'h76; cyc(3); rd(ADDR_STATUS); chk(rd_val[ST_TW_BIT], 1'b1);
      chk(switch_en, 1'b1);
      temp_meas = 8'h74; cyc(3); rd(ADDR_STATUS); chk(rd_val[ST_TW_BIT], 1'b0);
   endtask : t_thermal
   // Overcurrent opens switches and clears the ok bit
   task automatic t_overcurrent;
      iout_meas = 8'h3f; cyc(3); chk(switch_en, 1'b1);
      iout_meas = 8'h40; cyc(2); chk(switch_en, 1'b0);
      rd(ADDR_STATUS); chk(rd_val[ST_OC_BIT], 1'b0);
   endtask : t_overcurrent
   // Good window, status bit and external pull; a window exit is no shutdown
   task automatic t_good;
      chk({pg_out, pg_oe_n}, 2'b01);
      vout_meas = 12'h02e; cyc(2); chk(pg_oe_n, 1'b0);
      rd(ADDR_STATUS); chk(rd_val[ST_PG_BIT], 1'b0); chk(switch_en, 1'b1);
      vout_meas = 12'h028; cyc(2); chk(pg_oe_n, 1'b1);
      rd(ADDR_STATUS); chk(rd_val[ST_PG_BIT], 1'b1);
      ext_low = 1'b1; cyc(2); rd(ADDR_STATUS); chk(rd_val[ST_PG_BIT], 1'b0);
      ext_low = 1'b0; cyc(2); rd(ADDR_STATUS); chk(rd_val[ST_PG_BIT], 1'b1);
   endtask : t_good
   // Delayed turn-off with falling ramp; good pin held until ramp-down starts
   task automatic t_off;
      logic [VW-1:0] prev;
      int            n;
      wr(ADDR_RAMP_CFG, 8'h10);
      wr(ADDR_OFF_DELAY, 8'h0f);
      wr(ADDR_RUN, 8'h00);
      prev = vref;
      for (n = 0; n < 4000 && switch_en === 1'b1; n++) begin
         if (n == 800) chk({vref, pg_oe_n}, {12'h028, 1'b1});
         if (n == 1250) chk(pg_oe_n, 1'b0);
         cyc(1);
         if (vref !== prev) chk(prev - vref, 13'h004);
         prev = vref;
      end
      // 15 ms at two ticks per ms is 3000 cycles; the first tick may lag a period
      chk(n >= 2900 && n <= 3010, 1'b1);
      chk(vref, 12'h000);
   endtask : t_off
   // Turn-on into pre-bias, delayed good release, good low at the off command
   task automatic t_restart;
      int n;
      vout_meas = 12'h014; iout_meas = 8'h00;
      wr(ADDR_PG_DELAY, 8'hff); rd(ADDR_PG_DELAY); chk(rd_val, 8'h96);
      wr(ADDR_PG_DELAY, 8'h03);
      wr(ADDR_PG_MODE, 8'h01);
      wr(ADDR_RUN, 8'h01);
      cyc(300); chk(switch_en, 1'b0); chk(vref < 12'h014, 1'b1);
      for (n = 0; n < 2000 && switch_en !== 1'b1; n++) cyc(1);
      chk(vref, 12'h014);
      iout_meas = 8'h40; cyc(3); chk(switch_en, 1'b1);
      iout_meas = 8'h00;
      for (n = 0; n < 3000 && vref !== vset; n++) cyc(1);
      vout_meas = vset;
      cyc(300); chk(pg_oe_n, 1'b0);
      cyc(400); chk(pg_oe_n, 1'b1);
      wr(ADDR_RUN, 8'h00); cyc(3); chk({switch_en, pg_oe_n}, 2'b10);
   endtask : t_restart
   // Watchdog at 20000 cycles, about two and a half times the eight thousand cycles the scenarios take
   initial begin
      #400000;
      err_total++;
      print_verdict();
   end
   // Main sequence
   initial begin
      err_total = 0; tests_run = 0; reset = 1'b1; reg_addr = 8'h00; reg_wdata = 8'h00;
      reg_wr = 1'b0; reg_rd = 1'b0; vset = 12'h190; vout_meas = 12'h000; iout_meas = 8'h00; temp_meas = 8'h19;
      ext_low = 1'b0;
      repeat (12) @(posedge ref_clk);
      #1 reset = 1'b0;
      t_config();
      t_ramp();
      t_thermal();
      t_good();
      t_off();
      t_restart();
      t_overcurrent();
      print_verdict();
   end
endmodule : orps_supervisor_tb_top
